/* File: dv/epbc_buffer_ctrl_asserts.sv */
// port assertions for the packet buffer controller
`timescale 1ns/1ps
module epbc_buffer_ctrl_asserts (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic [4:0]  reg_idx_in,
  input wire logic        reg_wr_in,
  input wire logic [7:0]  reg_wr_data_in,
  input wire logic [7:0]  reg_rd_data_out,
  input wire logic        host_rd_req_in,
  input wire logic        host_rd_ready_out,
  input wire logic        host_rd_take_in,
  input wire logic        host_rd_valid_out,
  input wire logic [7:0]  host_rd_data_out,
  input wire logic        rx_valid_in,
  input wire logic        dma_wr_req_in,
  input wire logic [12:0] dma_wr_addr_in,
  input wire logic        dma_wr_ready_out,
  input wire logic [12:0] dma_wr_next_out,
  input wire logic [7:0]  pending_packet_count_out,
  input wire logic [12:0] tx_frame_start_out,
  input wire logic        sleep_out,
  input wire logic        regulator_low_current_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  AST_CTRL_RSVD: assert property (reg_idx_in == 5'h00 && !$past(reg_wr_in) |=> (reg_rd_data_out & 8'h57) == 8'h00)
    else $error("control register shows a zero bit set");
  AST_LOWCUR_SLEEP: assert property (regulator_low_current_out |-> sleep_out)
    else $error("low current without sleep");
  AST_SLEEP_ON: assert property (reg_wr_in && reg_idx_in == 5'h00 && reg_wr_data_in[5] ##1 !reg_wr_in |=> sleep_out)
    else $error("sleep not entered");
  AST_PKT_DEC: assert property (reg_wr_in && reg_idx_in == 5'h00 && reg_wr_data_in[6] && !rx_valid_in
    && !$past(rx_valid_in) && !$past(reg_wr_in) && pending_packet_count_out != 8'h00
    |=> ##1 pending_packet_count_out == $past(pending_packet_count_out) - 8'h01)
    else $error("packet count not lowered by one");
  AST_RD_VALID: assert property (host_rd_req_in && host_rd_ready_out |=> host_rd_valid_out)
    else $error("read byte not presented");
  AST_RD_HOLD: assert property (host_rd_valid_out && !host_rd_take_in |=> host_rd_valid_out && $stable(host_rd_data_out))
    else $error("read byte lost before take");
  AST_DMA_NEXT: assert property (dma_wr_req_in && dma_wr_ready_out |=> dma_wr_next_out == $past(dma_wr_addr_in) + 13'h0001)
    else $error("dma write address not advanced");
  AST_TX_START: assert property (reg_wr_in && reg_idx_in == 5'h0b ##1 !reg_wr_in |=> tx_frame_start_out[7:0] == $past(reg_wr_data_in, 2))
    else $error("transmit start not loaded");

  cover property (host_rd_valid_out && host_rd_take_in);
  cover property (dma_wr_req_in && dma_wr_ready_out);
  cover property (reg_wr_in && reg_idx_in == 5'h00 && reg_wr_data_in[6]);
endmodule // epbc_buffer_ctrl_asserts

bind epbc_buffer_ctrl epbc_buffer_ctrl_asserts u_chk (.*);

/* File: dv/epbc_buffer_ctrl_tb.sv */
// self-checking bench for the packet buffer controller
`timescale 1ns/1ps
module epbc_buffer_ctrl_tb;
  logic        clk_sys_in, sys_rst_in, rw, rq, rr, rv, tk, wq, wy, acc, xv, xl, xg, drq, dwq, dwr, slp, lcr, v1;
  logic        fp;
  logic [4:0]  ri;
  logic [7:0]  wd, rd, bd, hd, xd, drd, dwd, cnt, v8;
  logic [12:0] dra, drn, dwa, dwn, txs, txe;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;

  epbc_buffer_ctrl uut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_idx_in(ri), .reg_wr_in(rw),
    .reg_wr_data_in(wd), .reg_rd_data_out(rd), .host_rd_req_in(rq), .host_rd_ready_out(rr),
    .host_rd_data_out(bd), .host_rd_valid_out(rv), .host_rd_take_in(tk), .host_wr_req_in(wq),
    .host_wr_data_in(hd), .host_wr_ready_out(wy), .receive_accept_in(acc), .rx_filter_pass_in(fp),
    .rx_valid_in(xv), .rx_data_in(xd), .rx_last_in(xl), .rx_good_in(xg), .dma_rd_req_in(drq),
    .dma_rd_addr_in(dra), .dma_rd_data_out(drd), .dma_rd_next_out(drn), .dma_wr_req_in(dwq),
    .dma_wr_addr_in(dwa), .dma_wr_data_in(dwd), .dma_wr_ready_out(dwr), .dma_wr_next_out(dwn),
    .pending_packet_count_out(cnt), .tx_frame_start_out(txs), .tx_frame_end_out(txe),
    .sleep_out(slp), .regulator_low_current_out(lcr)
  );
  epbc_host_model host (
    .clk_sys_in(clk_sys_in), .reg_rd_data_in(rd), .rd_ready_in(rr), .rd_valid_in(rv), .rd_data_in(bd),
    .wr_ready_in(wy), .reg_idx_out(ri), .reg_wr_out(rw), .reg_data_out(wd), .rd_req_out(rq),
    .rd_take_out(tk), .wr_req_out(wq), .wr_data_out(hd)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic stop_test;
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic creg(input logic [4:0] i, input logic [7:0] e);
    host.rd(i, v8);
    chk("register", 13'(v8), 13'(e));
  endtask

  task automatic cptr(input logic [4:0] i, input logic [12:0] e);
    logic [7:0] lo;
    host.rd(i, lo);
    host.rd(i + 5'h01, v8);
    chk("pointer", {v8[4:0], lo}, e);
  endtask

  task automatic cbuf(input logic [7:0] e);
    host.br(v8, v1);
    chk("read valid", 13'(v1), 13'h0001);
    chk("read byte", 13'(v8), 13'(e));
  endtask

  task automatic rx_frame(input logic [7:0] b, input int n, input logic g);
    for (int k = 0; k < n; k++) begin
      @(negedge clk_sys_in);
      {xv, xd, xl, xg} = {1'b1, b + 8'(k), k == n - 1, g};
    end
    @(negedge clk_sys_in);
    {xv, xl} = 2'b00;
    repeat (2) @(negedge clk_sys_in);
  endtask

  task automatic dmar(input logic [12:0] a, input logic [7:0] e, input logic [12:0] n);
    @(negedge clk_sys_in);
    {drq, dra} = {1'b1, a};
    @(negedge clk_sys_in);
    drq = 1'b0;
    chk("dma byte", 13'(drd), 13'(e));
    chk("dma next", drn, n);
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst_in = 1'b1;
    {acc, xv, xl, xg, drq, dwq, xd, dwd, dra, dwa} = 48'h0;
    fp = 1'b1;
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    creg(5'h00, 8'h80);
    cptr(5'h07, 13'h1fff);
    host.wr(5'h00, 8'he8);
    creg(5'h00, 8'ha8);
    chk("sleep", 13'(slp), 13'h0001);
    chk("low current", 13'(lcr), 13'h0001);
    host.wr(5'h00, 8'h88);
    creg(5'h00, 8'h88);
    chk("sleep", 13'(slp), 13'h0000);
    chk("low current", 13'(lcr), 13'h0000);
    host.wr(5'h00, 8'h80);
    host.wp(5'h05, 13'h1ffc);
    host.wp(5'h07, 13'h0003);
    host.wp(5'h09, 13'h1000);
    acc = 1'b1;
    rx_frame(8'h10, 8, 1'b1);
    cptr(5'h0f, 13'h1ffc);
    creg(5'h11, 8'h01);
    host.wp(5'h01, 13'h0002);
    cbuf(8'h16);
    cbuf(8'h17);
    cbuf(8'h10);
    cptr(5'h01, 13'h1ffd);
    host.wp(5'h09, 13'h1ffe);
    rx_frame(8'h20, 4, 1'b1);
    creg(5'h11, 8'h01);
    host.wp(5'h01, 13'h1ffe);
    cbuf(8'h12);
    cbuf(8'h13);
    host.wp(5'h09, 13'h1000);
    acc = 1'b0;
    rx_frame(8'h30, 2, 1'b1);
    acc = 1'b1;
    fp = 1'b0;
    rx_frame(8'h38, 2, 1'b1);
    fp = 1'b1;
    rx_frame(8'h40, 2, 1'b0);
    creg(5'h11, 8'h01);
    cptr(5'h0f, 13'h1ffc);
    host.wr(5'h00, 8'hc0);
    creg(5'h11, 8'h00);
    creg(5'h00, 8'h80);
    host.wp(5'h03, 13'h0003);
    host.bw(8'haa);
    host.bw(8'hbb);
    cptr(5'h03, 13'h0005);
    host.wp(5'h01, 13'h0004);
    cbuf(8'hbb);
    host.wp(5'h03, 13'h1fff);
    host.bw(8'hcc);
    cptr(5'h03, 13'h0000);
    host.wr(5'h00, 8'h00);
    host.wp(5'h01, 13'h0003);
    cbuf(8'haa);
    cbuf(8'haa);
    cptr(5'h01, 13'h0003);
    dmar(13'h0003, 8'haa, 13'h1ffc);
    @(negedge clk_sys_in);
    {dwq, dwa, dwd} = {1'b1, 13'h1fff, 8'h5a};
    while (dwr !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    dwq = 1'b0;
    chk("dma write next", dwn, 13'h0000);
    dmar(13'h1fff, 8'h5a, 13'h0000);
    host.wp(5'h0b, 13'h0100);
    host.wp(5'h0d, 13'h01ff);
    @(negedge clk_sys_in);
    chk("tx start", txs, 13'h0100);
    chk("tx end", txe, 13'h01ff);
    stop_test();
  end
endmodule // epbc_buffer_ctrl_tb

/* File: dv/epbc_host_model.sv */
// host side model: register port and buffer data port tasks
`timescale 1ns/1ps
module epbc_host_model (
  // clock
  input  wire logic       clk_sys_in,
  // answers from the device
  input  wire logic [7:0] reg_rd_data_in,
  input  wire logic       rd_ready_in,
  input  wire logic       rd_valid_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       wr_ready_in,
  // requests to the device
  output logic      [4:0] reg_idx_out,
  output logic            reg_wr_out,
  output logic      [7:0] reg_data_out,
  output logic            rd_req_out,
  output logic            rd_take_out,
  output logic            wr_req_out,
  output logic      [7:0] wr_data_out
);
  initial begin
    {reg_idx_out, reg_wr_out, reg_data_out} = 14'h0000;
    {rd_req_out, rd_take_out, wr_req_out, wr_data_out} = 11'h000;
  end

  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_idx_out = i;
    reg_data_out = (i == 5'h00) ? (d & 8'hef) : d;
    reg_wr_out = 1'b1;
    @(negedge clk_sys_in);
    reg_wr_out = 1'b0;
  endtask

  // pointer pair: low byte then high byte
  task automatic wp(input logic [4:0] i, input logic [12:0] p);
    wr(i, p[7:0]);
    wr(i + 5'h01, {3'h0, p[12:8]});
  endtask

  task automatic rd(input logic [4:0] i, output logic [7:0] d);
    @(negedge clk_sys_in);
    reg_idx_out = i;
    @(negedge clk_sys_in);
    d = reg_rd_data_in;
  endtask

  task automatic bw(input logic [7:0] d);
    @(negedge clk_sys_in);
    wr_req_out = 1'b1;
    wr_data_out = d;
    while (wr_ready_in !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    wr_req_out = 1'b0;
  endtask

  task automatic br(output logic [7:0] d, output logic v);
    @(negedge clk_sys_in);
    rd_req_out = 1'b1;
    while (rd_ready_in !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    rd_req_out = 1'b0;
    v = rd_valid_in;
    d = rd_data_in;
    rd_take_out = 1'b1;
    @(negedge clk_sys_in);
    rd_take_out = 1'b0;
  endtask
endmodule // epbc_host_model

/* File: verilog/epbc_buffer_ctrl.sv */
// packet buffer controller: memory, receive ring, host and dma access
//
// Summary of operation
// R01 - auto-advance moves host pointer after each access
// R02 - decrement bit lowers packet count by one
// R03 - decrement bit clears itself after each set
// R04 - sleep bit puts mac, phy, control asleep
// R05 - regulator low-current bit only counts while asleep
// R06 - low three control bits read zero
// R07 - eight kilobyte memory shared by receive, transmit
// R08 - ring start and end bytes both inside
// R09 - receive writes sequential, wrap end to start
// R10 - host changes ring bounds only while reception off
// R11 - ring works across top-to-zero boundary
// R12 - fill pointer read-only, moved on good packet
// R13 - receive never writes guard pointer location
// R14 - full ring drops new data, keeps old
// R15 - host advances guard pointer after processing
// R16 - host sets transmit bounds per frame
// R17 - host avoids transmit bounds overlapping ring
// R18 - host sequential reads wrap at ring end
// R19 - host sequential writes never wrap
// R20 - dma reads wrap at ring end, writes not
// R21 - store filtered packets only while accept set
// R22 - thirteen-bit pointers roll over modulo memory
`timescale 1ns/1ps

module epbc_buffer_ctrl (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // control register port
  input  wire logic [4:0]  reg_idx_in,
  input  wire logic        reg_wr_in,
  input  wire logic [7:0]  reg_wr_data_in,
  output logic      [7:0]  reg_rd_data_out,
  // host buffer data port, read side
  input  wire logic        host_rd_req_in,
  output logic             host_rd_ready_out,
  output logic      [7:0]  host_rd_data_out,
  output logic             host_rd_valid_out,
  input  wire logic        host_rd_take_in,
  // host buffer data port, write side
  input  wire logic        host_wr_req_in,
  input  wire logic [7:0]  host_wr_data_in,
  output logic             host_wr_ready_out,
  // receive byte stream
  input  wire logic        receive_accept_in,
  input  wire logic        rx_filter_pass_in,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_last_in,
  input  wire logic        rx_good_in,
  // dma engine
  input  wire logic        dma_rd_req_in,
  input  wire logic [12:0] dma_rd_addr_in,
  output logic      [7:0]  dma_rd_data_out,
  output logic      [12:0] dma_rd_next_out,
  input  wire logic        dma_wr_req_in,
  input  wire logic [12:0] dma_wr_addr_in,
  input  wire logic [7:0]  dma_wr_data_in,
  output logic             dma_wr_ready_out,
  output logic      [12:0] dma_wr_next_out,
  // status and power
  output logic      [7:0]  pending_packet_count_out,
  output logic      [12:0] tx_frame_start_out,
  output logic      [12:0] tx_frame_end_out,
  output logic             sleep_out,
  output logic             regulator_low_current_out
);

  // ----------------------------------------------------------------
  // ring stepping
  // ----------------------------------------------------------------
  function automatic logic [12:0] ring_step(input logic [12:0] ptr,
                                            input logic [12:0] ring_end,
                                            input logic [12:0] ring_start);
    ring_step = (ptr == ring_end) ? ring_start : ptr + epbc_pkg::EPBC_ADDR_ONE; // R08 R09 R11 R22
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]  mem [0:epbc_pkg::EPBC_MEM_SIZE-1]; // R07
  logic [12:0] ptr      [0:epbc_pkg::EPBC_NUM_PTR-1];
  logic [12:0] next_ptr [0:epbc_pkg::EPBC_NUM_PTR-1];
  logic        auto_advance;
  logic        sleep_request;
  logic        regulator_low_current;
  logic [12:0] rx_fill_pointer;
  logic [12:0] rx_work;
  logic [7:0]  pkt_count;
  epbc_pkg::epbc_rx_state_t rx_state;
  epbc_pkg::epbc_rx_state_t next_rx_state;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire       ctrl_wr   = reg_wr_in && (reg_idx_in == epbc_pkg::EPBC_IDX_CTRL);
  wire       pkt_dec   = ctrl_wr && reg_wr_data_in[epbc_pkg::EPBC_BIT_PKT_DEC]; // R02 R03
  wire [4:0] ptr_off   = reg_idx_in - epbc_pkg::EPBC_IDX_PTR_BASE;
  wire [3:0] ptr_slot  = ptr_off[4:1];
  wire       ptr_hi    = ptr_off[0];
  wire       ptr_hit   = (reg_idx_in >= epbc_pkg::EPBC_IDX_PTR_BASE)
                         && (ptr_slot < 4'(epbc_pkg::EPBC_NUM_PTR));

  wire [12:0] ring_st = ptr[epbc_pkg::EPBC_P_RX_ST];
  wire [12:0] ring_nd = ptr[epbc_pkg::EPBC_P_RX_ND];
  wire [12:0] guard   = ptr[epbc_pkg::EPBC_P_GUARD];

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  wire        rx_start_ok = receive_accept_in && rx_filter_pass_in && !sleep_request; // R21 R04
  wire        rx_idle     = (rx_state == epbc_pkg::EPBC_RX_IDLE);
  wire        rx_storing  = rx_valid_in && ((rx_idle && rx_start_ok) || (rx_state == epbc_pkg::EPBC_RX_STORE));
  wire [12:0] rx_addr     = rx_idle ? rx_fill_pointer : rx_work;
  wire        rx_room     = (rx_addr != guard); // R13
  wire        rx_we       = rx_storing && rx_room; // R14
  wire [12:0] rx_addr_nx  = ring_step(rx_addr, ring_nd, ring_st); // R09 R11
  wire        rx_commit   = rx_we && rx_last_in && rx_good_in; // R12

  always_comb begin
    next_rx_state = rx_state;
    if (rx_valid_in) begin
      if (rx_last_in) begin
        next_rx_state = epbc_pkg::EPBC_RX_IDLE;
      end else if (rx_we) begin
        next_rx_state = epbc_pkg::EPBC_RX_STORE;
      end else begin
        next_rx_state = epbc_pkg::EPBC_RX_DROP; // R14 R21
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_state <= epbc_pkg::EPBC_RX_IDLE;
      rx_work  <= epbc_pkg::EPBC_PTR_RST;
    end else begin
      rx_state <= next_rx_state;
      if (rx_we) begin
        rx_work <= rx_addr_nx;
      end
    end
  end

  // ----------------------------------------------------------------
  // write arbitration: receive, then host, then dma
  // ----------------------------------------------------------------
  wire host_we = host_wr_req_in && !rx_we;
  wire dma_we  = dma_wr_req_in && !rx_we && !host_wr_req_in;

  assign host_wr_ready_out = !rx_we;
  assign dma_wr_ready_out  = !rx_we && !host_wr_req_in;

  wire [12:0] mem_waddr = rx_we   ? rx_addr :
                          host_we ? ptr[epbc_pkg::EPBC_P_HOST_WR] : dma_wr_addr_in;
  wire [7:0]  mem_wdata = rx_we   ? rx_data_in :
                          host_we ? host_wr_data_in : dma_wr_data_in;
  wire        mem_we    = rx_we || host_we || dma_we;

  always_ff @(posedge clk_sys_in) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // host read staging buffer, two entries
  // ----------------------------------------------------------------
  logic [7:0] rd_slot [0:1];
  logic       rd_wsel;
  logic       rd_rsel;
  logic [1:0] rd_count;
  wire        rd_full = (rd_count == 2'd2);
  wire        rd_push = host_rd_req_in && !rd_full;
  wire        rd_pop  = host_rd_take_in && (rd_count != 2'd0);

  assign host_rd_ready_out = !rd_full;
  assign host_rd_valid_out = (rd_count != 2'd0);
  assign host_rd_data_out  = rd_slot[rd_rsel];

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_wsel    <= 1'b0;
      rd_rsel    <= 1'b0;
      rd_count   <= 2'd0;
      rd_slot[0] <= 8'h00;
      rd_slot[1] <= 8'h00;
    end else begin
      if (rd_push) begin
        rd_slot[rd_wsel] <= mem[ptr[epbc_pkg::EPBC_P_HOST_RD]];
        rd_wsel          <= !rd_wsel;
      end
      if (rd_pop) begin
        rd_rsel <= !rd_rsel;
      end
      rd_count <= rd_count + {1'b0, rd_push} - {1'b0, rd_pop};
    end
  end

  // ----------------------------------------------------------------
  // pointer registers
  // ----------------------------------------------------------------
  wire [12:0] host_rd_nx = ring_step(ptr[epbc_pkg::EPBC_P_HOST_RD], ring_nd, ring_st); // R18
  wire [12:0] host_wr_nx = ptr[epbc_pkg::EPBC_P_HOST_WR] + epbc_pkg::EPBC_ADDR_ONE; // R19 R22

  genvar gi;
  generate
    for (gi = 0; gi < epbc_pkg::EPBC_NUM_PTR; gi++) begin : g_ptr
      wire hit = reg_wr_in && ptr_hit && (ptr_slot == 4'(gi));
      always_comb begin
        next_ptr[gi] = ptr[gi];
        if (hit && ptr_hi) begin
          next_ptr[gi] = {reg_wr_data_in[4:0], ptr[gi][7:0]};
        end else if (hit) begin
          next_ptr[gi] = {ptr[gi][12:8], reg_wr_data_in};
        end else if (gi == epbc_pkg::EPBC_P_HOST_RD && rd_push && auto_advance) begin
          next_ptr[gi] = host_rd_nx; // R01
        end else if (gi == epbc_pkg::EPBC_P_HOST_WR && host_we && auto_advance) begin
          next_ptr[gi] = host_wr_nx; // R01
        end
      end
      always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          ptr[gi] <= (gi == epbc_pkg::EPBC_P_RX_ND) ? epbc_pkg::EPBC_RX_ND_RST : epbc_pkg::EPBC_PTR_RST;
        end else begin
          ptr[gi] <= next_ptr[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // fill pointer and packet counter
  // ----------------------------------------------------------------
  wire ring_st_wr = reg_wr_in && ptr_hit && (ptr_slot == 4'(epbc_pkg::EPBC_P_RX_ST));
  wire pkt_inc    = rx_commit && (pkt_count != epbc_pkg::EPBC_PKT_MAX);
  wire pkt_dn     = pkt_dec && (pkt_count != epbc_pkg::EPBC_PKT_RST);

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_fill_pointer <= epbc_pkg::EPBC_PTR_RST;
      pkt_count       <= epbc_pkg::EPBC_PKT_RST;
    end else begin
      if (rx_commit) begin
        rx_fill_pointer <= rx_addr_nx; // R12
      end else if (ring_st_wr) begin
        rx_fill_pointer <= next_ptr[epbc_pkg::EPBC_P_RX_ST];
      end
      if (pkt_inc && !pkt_dn) begin
        pkt_count <= pkt_count + 8'h01;
      end else if (pkt_dn && !pkt_inc) begin
        pkt_count <= pkt_count - 8'h01; // R02
      end
    end
  end

  // ----------------------------------------------------------------
  // buffer_power_control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      auto_advance          <= epbc_pkg::EPBC_CTRL_RST[epbc_pkg::EPBC_BIT_AUTO_ADV];
      sleep_request         <= epbc_pkg::EPBC_CTRL_RST[epbc_pkg::EPBC_BIT_SLEEP];
      regulator_low_current <= epbc_pkg::EPBC_CTRL_RST[epbc_pkg::EPBC_BIT_REG_LOW];
    end else if (ctrl_wr) begin
      auto_advance          <= reg_wr_data_in[epbc_pkg::EPBC_BIT_AUTO_ADV];
      sleep_request         <= reg_wr_data_in[epbc_pkg::EPBC_BIT_SLEEP]; // R04
      regulator_low_current <= reg_wr_data_in[epbc_pkg::EPBC_BIT_REG_LOW];
    end
  end

  wire [7:0] ctrl_view = {auto_advance, 1'b0, sleep_request, 1'b0, regulator_low_current, 3'b000}; // R03 R06

  // ----------------------------------------------------------------
  // register read and data outputs
  // ----------------------------------------------------------------
  wire [12:0] ptr_sel  = ptr[ptr_slot[2:0]];
  wire [7:0]  ptr_byte = ptr_hi ? {3'b000, ptr_sel[12:8]} : ptr_sel[7:0];
  wire [7:0]  rd_mux   = (reg_idx_in == epbc_pkg::EPBC_IDX_CTRL)    ? ctrl_view :
                         ptr_hit                                    ? ptr_byte :
                         (reg_idx_in == epbc_pkg::EPBC_IDX_FILL_LO) ? rx_fill_pointer[7:0] :
                         (reg_idx_in == epbc_pkg::EPBC_IDX_FILL_HI) ? {3'b000, rx_fill_pointer[12:8]} :
                         (reg_idx_in == epbc_pkg::EPBC_IDX_PKT_CNT) ? pkt_count : 8'h00;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rd_data_out           <= 8'h00;
      dma_rd_data_out           <= 8'h00;
      dma_rd_next_out           <= epbc_pkg::EPBC_PTR_RST;
      dma_wr_next_out           <= epbc_pkg::EPBC_PTR_RST;
      pending_packet_count_out  <= epbc_pkg::EPBC_PKT_RST;
      tx_frame_start_out        <= epbc_pkg::EPBC_PTR_RST;
      tx_frame_end_out          <= epbc_pkg::EPBC_PTR_RST;
      sleep_out                 <= 1'b0;
      regulator_low_current_out <= 1'b0;
    end else begin
      reg_rd_data_out <= rd_mux;
      if (dma_rd_req_in) begin
        dma_rd_data_out <= mem[dma_rd_addr_in];
        dma_rd_next_out <= ring_step(dma_rd_addr_in, ring_nd, ring_st); // R20
      end
      if (dma_we) begin
        dma_wr_next_out <= dma_wr_addr_in + epbc_pkg::EPBC_ADDR_ONE; // R20
      end
      pending_packet_count_out  <= pkt_count;
      tx_frame_start_out        <= ptr[epbc_pkg::EPBC_P_TX_ST];
      tx_frame_end_out          <= ptr[epbc_pkg::EPBC_P_TX_ND];
      sleep_out                 <= sleep_request;
      regulator_low_current_out <= sleep_request && regulator_low_current; // R05
    end
  end

endmodule // epbc_buffer_ctrl

/* File: verilog/epbc_pkg.sv */
// constants for the packet buffer controller
package epbc_pkg;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int          EPBC_ADDR_W   = 13;
  localparam int          EPBC_MEM_SIZE = 8192;
  localparam logic [12:0] EPBC_ADDR_ONE = 13'h0001;

  // ----------------------------------------------------------------
  // control register index map
  // ----------------------------------------------------------------
  localparam int          EPBC_IDX_W        = 5;
  localparam logic [4:0]  EPBC_IDX_CTRL     = 5'h00;
  localparam logic [4:0]  EPBC_IDX_PTR_BASE = 5'h01;
  localparam logic [4:0]  EPBC_IDX_FILL_LO  = 5'h0f;
  localparam logic [4:0]  EPBC_IDX_FILL_HI  = 5'h10;
  localparam logic [4:0]  EPBC_IDX_PKT_CNT  = 5'h11;

  // pointer slots, each a low/high byte pair from EPBC_IDX_PTR_BASE
  localparam int          EPBC_NUM_PTR   = 7;
  localparam int          EPBC_P_HOST_RD = 0;
  localparam int          EPBC_P_HOST_WR = 1;
  localparam int          EPBC_P_RX_ST   = 2;
  localparam int          EPBC_P_RX_ND   = 3;
  localparam int          EPBC_P_GUARD   = 4;
  localparam int          EPBC_P_TX_ST   = 5;
  localparam int          EPBC_P_TX_ND   = 6;

  // ----------------------------------------------------------------
  // buffer_power_control fields
  // ----------------------------------------------------------------
  localparam int          EPBC_BIT_AUTO_ADV  = 7;
  localparam int          EPBC_BIT_PKT_DEC   = 6;
  localparam int          EPBC_BIT_SLEEP     = 5;
  localparam int          EPBC_BIT_REG_LOW   = 3;
  localparam logic [7:0]  EPBC_CTRL_RST      = 8'h80;

  // ----------------------------------------------------------------
  // reset values of pointers and counter, and counter limit
  // ----------------------------------------------------------------
  localparam logic [12:0] EPBC_PTR_RST    = 13'h0000;
  localparam logic [12:0] EPBC_RX_ND_RST  = 13'h1fff;
  localparam logic [7:0]  EPBC_PKT_RST    = 8'h00;
  localparam logic [7:0]  EPBC_PKT_MAX    = 8'hff;

  // ----------------------------------------------------------------
  // receive state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EPBC_RX_IDLE  = 2'b00,
    EPBC_RX_STORE = 2'b01,
    EPBC_RX_DROP  = 2'b11
  } epbc_rx_state_t;

endpackage
